// ---- srco_top.sv ----
// Reset distribution, watchdog reset output and clock outputs.
// Assumes the reset pin and requests are synchronous to i_clk_sys and
// that pad cells tri-state each pin while its enable is low.
//
// Contract
// - Reset pin holds core and blocks reset
// - All pins tri-stated during reset
// - Watchdog expiry drives reset out 200ms
// - Differential memory clocks from system clock
// - Clock enable powers down the SDRAM
// - 25MHz reference clock to PHY, tri-stated during reset
module srco_top
    import srco_pkg::*;
#(
    parameter int WDOG_RST_CYC = srco_pkg::SRCO_WDOG_RST_CYC,
    parameter int MEM_CLK_PAIRS = srco_pkg::SRCO_MEM_CLK_PAIRS
) (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_wdog_expire,
    input wire logic i_mem_pdown_req,
    output logic o_blk_rst_n,
    output logic o_pin_oe,
    output logic o_wdog_rst_out,
    output logic o_wdog_rst_out_oe,
    output logic [MEM_CLK_PAIRS-1:0] o_mem_clk_out_p,
    output logic [MEM_CLK_PAIRS-1:0] o_mem_clk_out_n,
    output logic o_mem_clk_oe,
    output logic o_mem_clk_en_out,
    output logic o_phy_ref_clk_out,
    output logic o_phy_ref_clk_oe
);
    import srco_pkg::*;

    srco_state_s st_r;
    srco_state_s st_nxt;
    logic wdog_active;
    logic rel_done;

    // ----------------------------------------------------------------
    // State decoding, shared by the sequencer and the outputs
    // ----------------------------------------------------------------
    // Far end of the release pipe: high once reset has been let go
    function automatic logic srco_rel_done(
        input logic [1:0] pipe
    );
        logic done;
        done = pipe[1];
        return done;
    endfunction : srco_rel_done

    // Shifts a one into the release pipe each cycle out of reset
    function automatic logic [1:0] srco_sync_shift(
        input logic [1:0] pipe
    );
        logic [1:0] shifted;
        shifted = {pipe[0], 1'h1};
        return shifted;
    endfunction : srco_sync_shift

    // Only the three coded states are legal; anything else restarts
    function automatic logic srco_state_known(
        input srco_state_e st
    );
        logic known;
        case (st)
            SRCO_ST_RESET: begin
                known = 1'h1;
            end
            SRCO_ST_RUN: begin
                known = 1'h1;
            end
            SRCO_ST_PDOWN: begin
                known = 1'h1;
            end
            default: begin
                known = 1'h0;
            end
        endcase
        return known;
    endfunction : srco_state_known

    // Next state from the release pipe and the power-down request
    function automatic srco_state_e srco_step(
        input srco_state_e st,
        input logic released,
        input logic pdown_req
    );
        srco_state_e st_next;
        case (st)
            SRCO_ST_RESET: begin
                if (released) begin
                    st_next = SRCO_ST_RUN;
                end else begin
                    st_next = SRCO_ST_RESET;
                end
            end
            SRCO_ST_RUN: begin
                if (pdown_req) begin
                    st_next = SRCO_ST_PDOWN;
                end else begin
                    st_next = SRCO_ST_RUN;
                end
            end
            SRCO_ST_PDOWN: begin
                if (pdown_req) begin
                    st_next = SRCO_ST_PDOWN;
                end else begin
                    st_next = SRCO_ST_RUN;
                end
            end
            default: begin
                st_next = SRCO_ST_RESET;
            end
        endcase
        return st_next;
    endfunction : srco_step

    // Pads drive once the release pipe has run through
    function automatic logic srco_pins_live(
        input srco_state_e st
    );
        logic live;
        case (st)
            SRCO_ST_RESET: begin
                live = 1'h0;
            end
            SRCO_ST_RUN: begin
                live = 1'h1;
            end
            SRCO_ST_PDOWN: begin
                live = 1'h1;
            end
            default: begin
                live = 1'h0;
            end
        endcase
        return live;
    endfunction : srco_pins_live

    // Memory clock enable is high only while running
    function automatic logic srco_mem_clk_run(
        input srco_state_e st
    );
        logic run;
        case (st)
            SRCO_ST_RUN: begin
                run = 1'h1;
            end
            default: begin
                run = 1'h0;
            end
        endcase
        return run;
    endfunction : srco_mem_clk_run

    // ----------------------------------------------------------------
    // Reset sequencing and power-down control
    // ----------------------------------------------------------------
    assign rel_done = srco_rel_done(st_r.sync);

    always_comb begin
        st_nxt = st_r;
        st_nxt.sync = srco_sync_shift(st_r.sync);
        st_nxt.state = srco_step(st_r.state, rel_done, i_mem_pdown_req);
        st_nxt.oe = srco_pins_live(st_nxt.state);
        // Clock enable low in power down
        st_nxt.cke = srco_mem_clk_run(st_nxt.state);
        // Stray codes restart the whole sequence
        if (!srco_state_known(st_r.state)) begin
            st_nxt = SRCO_STATE_RST;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            st_r <= SRCO_STATE_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    // Block reset from pipe
    assign o_blk_rst_n = st_r.sync[1];
    assign o_pin_oe = st_r.oe;
    assign o_wdog_rst_out_oe = st_r.oe;
    assign o_mem_clk_oe = st_r.oe;
    assign o_phy_ref_clk_oe = st_r.oe;
    assign o_mem_clk_en_out = st_r.cke;

    // ----------------------------------------------------------------
    // Watchdog reset output
    // ----------------------------------------------------------------
    // Stretch expiry pulse
    srco_pulse_stretch #(
        .CNT(WDOG_RST_CYC)
    ) u_wdog_stretch (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(rel_done),
        .i_trig(i_wdog_expire),
        .o_active(wdog_active)
    );

    assign o_wdog_rst_out = wdog_active;

    // ----------------------------------------------------------------
    // Clock outputs, forwarded from the system clock
    // ----------------------------------------------------------------
    // A flop cannot carry a clock at its own rate, so these pass the
    // clock through; only the enables come from flops.
    genvar g;
    generate
        for (g = 0; g < MEM_CLK_PAIRS; g++) begin : g_mem_clk
            assign o_mem_clk_out_p[g] = i_clk_sys;
            assign o_mem_clk_out_n[g] = ~i_clk_sys;
        end
    endgenerate

    assign o_phy_ref_clk_out = i_clk_sys;

endmodule : srco_top

// ---- srco_pkg.sv ----
// Constants, states and state record of the reset and clock output block.
// Assumes one system clock at SRCO_SYS_CLK_HZ.
package srco_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam longint SRCO_SYS_CLK_HZ = 25000000;
    localparam int SRCO_RST_IN_MIN_CYC = 256;
    localparam longint SRCO_WDOG_RST_MS = 200;
    localparam int SRCO_WDOG_RST_CYC =
        int'((SRCO_WDOG_RST_MS * SRCO_SYS_CLK_HZ + 999) / 1000);
    localparam int SRCO_MEM_CLK_PAIRS = 2;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] SRCO_SYNC_RST = 2'h0;
    localparam logic SRCO_OE_RST = 1'h0;
    localparam logic SRCO_CKE_RST = 1'h0;

    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SRCO_ST_RESET = 3'h1,
        SRCO_ST_RUN = 3'h2,
        SRCO_ST_PDOWN = 3'h4
    } srco_state_e;

    typedef struct packed {
        srco_state_e state;
        logic [1:0] sync;
        logic oe;
        logic cke;
    } srco_state_s;

    localparam srco_state_s SRCO_STATE_RST = '{
        state: SRCO_ST_RESET,
        sync: SRCO_SYNC_RST,
        oe: SRCO_OE_RST,
        cke: SRCO_CKE_RST
    };

endpackage : srco_pkg

// ---- srco_pulse_stretch.sv ----
// Stretches a one-cycle trigger into a pulse of at least CNT cycles.
// Assumes a synchronous active-low reset already aligned to the clock.
module srco_pulse_stretch #(
    parameter int CNT = 5000000
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_trig,
    output logic o_active
);
    localparam int CW = $clog2(CNT + 1);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic active;
    } srco_ps_s;

    srco_ps_s st_r;
    srco_ps_s st_nxt;

    // ----------------------------------------------------------------
    // Down counter, reloaded by every trigger
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (i_trig) begin
            st_nxt.cnt = CW'(CNT);
        end else if (st_r.cnt != '0) begin
            st_nxt.cnt = st_r.cnt - CW'(1);
        end
        st_nxt.active = (st_nxt.cnt != '0);
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_active = st_r.active;

endmodule : srco_pulse_stretch

// ---- srco_board.sv ----
// Board reset circuit: stretches a short kick into a long reset.
// Assumes the kick is synchronous to the system clock.
module srco_board (
    input wire logic i_clk_sys,
    input wire logic i_kick_n,
    output logic o_nrst
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HOLD = srco_pkg::SRCO_RST_IN_MIN_CYC;
    int cnt = 0;
    always @(posedge i_clk_sys) cnt <= i_kick_n ? cnt + (cnt < HOLD) : 0;
    assign o_nrst = (cnt == HOLD);
endmodule : srco_board

// ---- srco_top_chk.sv ----
// Port assertions of the reset and clock output block.
// Assumes binding to srco_top; one clock domain.
module srco_top_chk #(
    parameter int MEM_CLK_PAIRS = 2
) (
    input wire logic i_clk_sys,
    input wire logic i_nrst,
    input wire logic i_wdog_expire,
    input wire logic i_mem_pdown_req,
    input wire logic o_blk_rst_n,
    input wire logic o_pin_oe,
    input wire logic o_wdog_rst_out,
    input wire logic o_wdog_rst_out_oe,
    input wire logic [MEM_CLK_PAIRS-1:0] o_mem_clk_out_p,
    input wire logic [MEM_CLK_PAIRS-1:0] o_mem_clk_out_n,
    input wire logic o_mem_clk_oe,
    input wire logic o_mem_clk_en_out,
    input wire logic o_phy_ref_clk_out,
    input wire logic o_phy_ref_clk_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_clk_sys); endclocking
    sequence s_rel;
        $rose(i_nrst) ##1 i_nrst;
    endsequence
    sequence s_trig;
        i_wdog_expire && o_blk_rst_n;
    endsequence
    AST_RST_BLK: assert property (!i_nrst |=> !o_blk_rst_n)
        else $error("block reset missing");
    AST_RST_OE: assert property (!i_nrst |=> !(o_pin_oe ||
        o_wdog_rst_out_oe || o_mem_clk_oe || o_phy_ref_clk_oe))
        else $error("pin driven in reset");
    AST_WD_HOLD: assert property (disable iff (!i_nrst)
        s_trig |=> o_wdog_rst_out [*8]) else $error("watchdog out short");
    AST_WD_CLR: assert property (!o_blk_rst_n ##1 !o_blk_rst_n
        |=> !o_wdog_rst_out) else $error("watchdog out in reset");
    AST_MEM_DIFF: assert property (
        o_mem_clk_out_n == ~o_mem_clk_out_p
        && o_mem_clk_out_p == {MEM_CLK_PAIRS{i_clk_sys}})
        else $error("memory clock pair wrong");
    AST_CKE_OFF: assert property (i_nrst && o_mem_clk_oe
        && i_mem_pdown_req |=> !o_mem_clk_en_out) else $error("no pdown");
    AST_CKE_ON: assert property (i_nrst && o_mem_clk_oe
        && !i_mem_pdown_req |=> o_mem_clk_en_out) else $error("no wake");
    AST_PHY: assert property (o_phy_ref_clk_out == i_clk_sys)
        else $error("phy clock wrong");
    AST_REL: assert property (s_rel |-> !o_blk_rst_n ##1
        (o_blk_rst_n && !o_pin_oe)) else $error("release misaligned");
endmodule : srco_top_chk

// ---- system_reset_clock_outputs_test.sv ----
// Bench for srco_top with board model; watchdog length cut to 20.
// Assumes srco_pkg, srco_top, srco_board and the checker compiled.
module system_reset_clock_outputs_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int WCYC = 20;
    logic clk = 0, kick_n = 0, wd = 0, pd = 0, nrst, blk, oe, wo, woe;
    logic moe, cke, pck, poe;
    logic [1:0] mp, mn;
    logic [1:0] rows [4] = '{2'h2, 2'h2, 2'h1, 2'h1};
    int error_cnt = 0, checks_done = 0, k;
    srco_board u_srco_board (.i_clk_sys(clk), .i_kick_n(kick_n),
        .o_nrst(nrst));
    srco_top #(.WDOG_RST_CYC(WCYC)) u_srco_top (.i_clk_sys(clk),
        .i_nrst(nrst), .i_wdog_expire(wd), .i_mem_pdown_req(pd),
        .o_blk_rst_n(blk), .o_pin_oe(oe), .o_wdog_rst_out(wo),
        .o_wdog_rst_out_oe(woe), .o_mem_clk_out_p(mp), .o_mem_clk_out_n(mn),
        .o_mem_clk_oe(moe), .o_mem_clk_en_out(cke), .o_phy_ref_clk_out(pck),
        .o_phy_ref_clk_oe(poe));
    initial forever #20 clk = ~clk;
    task automatic cmp(input string nm, input logic e, input logic s);
        checks_done++;
        if (s !== e) begin
            error_cnt++;
            $display("FAIL %s exp %b got %b", nm, e, s);
        end
    endtask : cmp
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : step
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    task automatic rst_chk();
        cmp("blk_rst", 1'b0, blk);
        cmp("pin_oe", 1'b0, oe | woe | moe | poe | cke | wo);
        for (k = 0; k < 400 && oe !== 1'b1; k++) step(1);
        cmp("oe_up", 1'b1, oe & woe & moe & poe & blk);
        if (oe !== 1'b1) stop_test();
        $display("reset test done");
    endtask : rst_chk
    initial begin
        wd = 1'b1;
        step(4);
        kick_n = 1'b1;
        wd = 1'b0;
        rst_chk();
        repeat (2) begin
            cmp("phy_clk", clk, pck);
            cmp("mem_clk", 1'b1, mn === ~mp && mp === {2{clk}});
            #20;
        end
        $display("clock test done");
        for (int i = 0; i < 4; i++) begin
            pd = rows[i][1];
            step(1);
            cmp("cke", rows[i][0], cke);
        end
        $display("power down test done");
        wd = 1'b1;
        step(1);
        wd = 1'b0;
        for (k = 1; k < 100 && wo === 1'b1; k++) step(1);
        cmp("wdog_len", 1'b1, k == WCYC + 1);
        $display("watchdog test done");
        kick_n = 1'b0;
        step(1);
        kick_n = 1'b1;
        step(1);
        rst_chk();
        stop_test();
    end
endmodule : system_reset_clock_outputs_test
bind srco_top srco_top_chk #(.MEM_CLK_PAIRS(MEM_CLK_PAIRS)) u_srco_top_chk (.*);
